// ==== rtl/fta_pkg.sv ====
/*
 Shared constants and types for the flag/test/compare/shift datapath slice.
 Assumes an 8-bit core datapath clocked at 50 MHz with one operation per
 cycle presented by the instruction decoder.
*/
package fta_pkg;

   // Datapath width
   localparam int DATA_W = 8;

   // Values after reset, and the all-zero byte for flag compares
   localparam logic FLAG_RST = 1'b0;
   localparam logic [7:0] WB_DATA_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // Field positions inside the operation code
   localparam int OP_SHIFT_BIT = 3;
   localparam int OP_RIGHT_BIT = 2;

   // Fill selection for the vacated shift bit
   typedef enum logic [1:0] {
      FILL_ZERO = 2'h0,
      FILL_ONE = 2'h1,
      FILL_KEEP = 2'h2,
      FILL_CARRY = 2'h3
   } fta_fill_t;

   // Operation codes; codes 4..7 are unused and ignored
   typedef enum logic [3:0] {
      OP_MASK_CHECK = 4'h0,
      OP_CHAINED_MASK_CHECK = 4'h1,
      OP_SUBTRACT_CHECK = 4'h2,
      OP_CHAINED_SUBTRACT_CHECK = 4'h3,
      OP_LEFT_SHIFT_FILL_ZERO = 4'h8,
      OP_LEFT_SHIFT_FILL_ONE = 4'h9,
      OP_LEFT_SHIFT_KEEP_LOW = 4'ha,
      OP_LEFT_SHIFT_VIA_CARRY = 4'hb,
      OP_RIGHT_SHIFT_FILL_ZERO = 4'hc,
      OP_RIGHT_SHIFT_FILL_ONE = 4'hd,
      OP_RIGHT_SHIFT_KEEP_SIGN = 4'he,
      OP_RIGHT_SHIFT_VIA_CARRY = 4'hf
   } fta_op_t;

endpackage

// ==== rtl/fta_shifter.sv ====
/*
 Single-bit left/right shifter with selectable fill bit.
 Purely combinational; the caller registers result and carry.
*/
`timescale 1ns/10ps
module fta_shifter
   import fta_pkg::*;
(
   // Operand and control
   input wire logic [7:0] value,
   input wire logic right,
   input wire logic [1:0] fill_sel,
   input wire logic carry_in,
   // Results
   output logic [7:0] result,
   output logic carry_out
);

   logic fill_bit;
   logic keep_bit;

   // Old LSB for left shifts, old MSB for right shifts
   assign keep_bit = right ? value[7] : value[0];

   // Injected bit by variant
   always_comb begin
      unique case (fta_fill_t'(fill_sel))
         FILL_ZERO: fill_bit = 1'b0;
         FILL_ONE: fill_bit = 1'b1;
         FILL_KEEP: fill_bit = keep_bit;
         FILL_CARRY: fill_bit = carry_in;
      endcase
   end

   // Move one place and report the bit that leaves
   assign result = right ? {fill_bit, value[7:1]} : {value[6:0], fill_bit};
   assign carry_out = right ? value[0] : value[7];

endmodule

// ==== rtl/fta_alu.sv ====
/*
 Flag-producing datapath slice: masked test with parity, compare by
 subtraction, their chained multi-byte forms, and single-bit shifts.
 Holds the zero and carry flags of the core and returns shifted values
 for write-back. Assumes the decoder presents one operation per cycle
 with OP_VALID high and the register file accepts WB_DATA on WB_VALID.
*/
// How it works
// - Mask check ANDs both operands, updates flags only, register kept.
// - Second operand is the immediate byte or the second register.
// - Mask check sets null flag when the AND value is all zero.
// - Mask check borrow flag is XOR reduction of the AND value.
// - Chained mask null flag needs zero AND value and null flag set before.
// - Chained mask borrow flag is AND parity XOR previous borrow flag.
// - Subtract check forms first minus second, keeps only the two flags.
// - Subtract check null flag marks an all-zero difference, operands equal.
// - Subtract check borrow flag marks first below second, unsigned.
// - Chained subtract null flag needs zero difference and prior null flag.
// - Chained subtract borrow flag marks a negative difference with borrow.
// - Left shifts move toward MSB, old MSB goes to borrow flag.
// - Right shifts move toward LSB, old LSB goes to borrow flag.
// - After any shift null flag marks an all-zero written value.
// - Sign-keeping right shift refills MSB with its old value.
// - Via-carry shifts inject the incoming borrow flag.
`timescale 1ns/10ps
module fta_alu
   import fta_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Operation from the decoder
   input wire logic OP_VALID,
   input wire logic [3:0] OP_CODE,
   input wire logic USE_SECOND_REG,
   // Operands
   input wire logic [7:0] FIRST_OPERAND_REG,
   input wire logic [7:0] SECOND_OPERAND_REG,
   input wire logic [7:0] IMMEDIATE_BYTE,
   // Flags
   output logic RESULT_NULL_FLAG,
   output logic BORROW_OUT_FLAG,
   // Register write-back
   output logic WB_VALID,
   output logic [7:0] WB_DATA
);

   logic null_q;
   logic null_d;
   logic borrow_q;
   logic borrow_d;
   logic wb_valid_q;
   logic wb_valid_d;
   logic [7:0] wb_data_q;
   logic [7:0] wb_data_d;

   wire [7:0] operand_b;
   wire [7:0] and_val;
   wire [8:0] parity_chain;
   wire and_parity;
   wire [8:0] sub_plain;
   wire [8:0] sub_chained;
   wire [7:0] shift_val;
   wire shift_carry;
   wire is_shift;
   wire is_mask;
   wire is_cmask;
   wire is_sub;
   wire is_csub;
   wire op_known;

   // Operand selection
   assign operand_b = USE_SECOND_REG ? SECOND_OPERAND_REG : IMMEDIATE_BYTE;

   // Temporary AND value, never written back
   assign and_val = FIRST_OPERAND_REG & operand_b;

   // Parity ripple across the AND value
   assign parity_chain[0] = 1'b0;
   generate
      for (genvar i = 0; i < DATA_W; i++) begin : g_par
         assign parity_chain[i+1] = parity_chain[i] ^ and_val[i];
      end
   endgenerate
   assign and_parity = parity_chain[DATA_W];

   // Differences with a ninth bit as borrow
   assign sub_plain = {1'b0, FIRST_OPERAND_REG} - {1'b0, operand_b};
   assign sub_chained = {1'b0, FIRST_OPERAND_REG} - {1'b0, operand_b}
                        - {8'h00, borrow_q};

   // Operation decode
   assign is_shift = OP_CODE[OP_SHIFT_BIT];
   assign is_mask = OP_CODE == OP_MASK_CHECK;
   assign is_cmask = OP_CODE == OP_CHAINED_MASK_CHECK;
   assign is_sub = OP_CODE == OP_SUBTRACT_CHECK;
   assign is_csub = OP_CODE == OP_CHAINED_SUBTRACT_CHECK;
   assign op_known = is_shift | is_mask | is_cmask | is_sub | is_csub;

   // Shift unit
   fta_shifter u_shift (
      .value(FIRST_OPERAND_REG),
      .right(OP_CODE[OP_RIGHT_BIT]),
      .fill_sel(OP_CODE[1:0]),
      .carry_in(borrow_q),
      .result(shift_val),
      .carry_out(shift_carry)
   );

   // Next flag and write-back values
   always_comb begin
      null_d = null_q;
      borrow_d = borrow_q;
      wb_valid_d = 1'b0;
      wb_data_d = wb_data_q;
      if (OP_VALID) begin
         unique case (OP_CODE)
            OP_MASK_CHECK: begin
               null_d = and_val == ZERO_BYTE;
               borrow_d = and_parity;
            end
            OP_CHAINED_MASK_CHECK: begin
               null_d = (and_val == ZERO_BYTE) & null_q;
               borrow_d = and_parity ^ borrow_q;
            end
            OP_SUBTRACT_CHECK: begin
               null_d = sub_plain[7:0] == ZERO_BYTE;
               borrow_d = sub_plain[8];
            end
            OP_CHAINED_SUBTRACT_CHECK: begin
               null_d = (sub_chained[7:0] == ZERO_BYTE) & null_q;
               borrow_d = sub_chained[8];
            end
            OP_LEFT_SHIFT_FILL_ZERO, OP_LEFT_SHIFT_FILL_ONE,
            OP_LEFT_SHIFT_KEEP_LOW, OP_LEFT_SHIFT_VIA_CARRY,
            OP_RIGHT_SHIFT_FILL_ZERO, OP_RIGHT_SHIFT_FILL_ONE,
            OP_RIGHT_SHIFT_KEEP_SIGN, OP_RIGHT_SHIFT_VIA_CARRY: begin
               null_d = shift_val == ZERO_BYTE;
               borrow_d = shift_carry;
               wb_valid_d = 1'b1;
               wb_data_d = shift_val;
            end
            default: begin
               null_d = null_q;
               borrow_d = borrow_q;
            end
         endcase
      end
   end

   // Flag and write-back registers
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         null_q <= FLAG_RST;
         borrow_q <= FLAG_RST;
         wb_valid_q <= 1'b0;
         wb_data_q <= WB_DATA_RST;
      end else begin
         null_q <= null_d;
         borrow_q <= borrow_d;
         wb_valid_q <= wb_valid_d;
         wb_data_q <= wb_data_d;
      end
   end

   // Outputs straight from flops
   assign RESULT_NULL_FLAG = null_q;
   assign BORROW_OUT_FLAG = borrow_q;
   assign WB_VALID = wb_valid_q;
   assign WB_DATA = wb_data_q;

   // Checks on the flag and write-back behaviour
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   wire [7:0] b_sel = USE_SECOND_REG ? SECOND_OPERAND_REG : IMMEDIATE_BYTE;
   wire [7:0] chk_and = FIRST_OPERAND_REG & b_sel;
   wire [7:0] chk_cdiff = FIRST_OPERAND_REG - b_sel - {7'h00, BORROW_OUT_FLAG};

   // Only shifts write the register back
   no_wb_check_a: assert property (
      OP_VALID && !is_shift |=> !WB_VALID)
      else $error("write-back after a non-shift operation");

   // Non-shifts leave the last written value alone
   wb_hold_a: assert property (
      OP_VALID && !is_shift |=> $stable(WB_DATA))
      else $error("write-back data moved without a shift");

   // A zero second register must reach the AND
   operand_pick_a: assert property (
      OP_VALID && is_mask && USE_SECOND_REG && (SECOND_OPERAND_REG == 8'h00)
      |=> RESULT_NULL_FLAG)
      else $error("second register operand not used");

   // Zero flag after a plain mask check
   mask_null_a: assert property (
      OP_VALID && is_mask |=> RESULT_NULL_FLAG == ($past(chk_and) == 8'h00))
      else $error("mask check null flag wrong");

   // Carry flag is the odd parity of the AND value
   mask_parity_a: assert property (
      OP_VALID && is_mask |=> BORROW_OUT_FLAG == ^$past(chk_and))
      else $error("mask check parity wrong");

   // Chained mask keeps zero only across all bytes
   chain_mask_null_a: assert property (
      OP_VALID && is_cmask
      |=> RESULT_NULL_FLAG == (($past(chk_and) == 8'h00) && $past(RESULT_NULL_FLAG)))
      else $error("chained mask check null flag wrong");

   // Chained parity folds in the previous carry
   chain_mask_par_a: assert property (
      OP_VALID && is_cmask
      |=> BORROW_OUT_FLAG == (^$past(chk_and) ^ $past(BORROW_OUT_FLAG)))
      else $error("chained mask parity wrong");

   // Compares discard their difference
   sub_no_wb_a: assert property (
      OP_VALID && (is_sub || is_csub) |=> !WB_VALID && $stable(WB_DATA))
      else $error("subtract check disturbed write-back");

   // Equal operands give a zero flag
   sub_equal_a: assert property (
      OP_VALID && is_sub |=> RESULT_NULL_FLAG == ($past(FIRST_OPERAND_REG) == $past(b_sel)))
      else $error("subtract check equality flag wrong");

   // Equal and below can never both be flagged
   sub_flags_a: assert property (
      OP_VALID && is_sub |=> !(RESULT_NULL_FLAG && BORROW_OUT_FLAG))
      else $error("subtract check flags contradict");

   // Unsigned less-than gives the carry flag
   sub_less_a: assert property (
      OP_VALID && is_sub |=> BORROW_OUT_FLAG == ($past(FIRST_OPERAND_REG) < $past(b_sel)))
      else $error("subtract check borrow flag wrong");

   // Chained compare subtracts the incoming carry as well
   csub_diff_a: assert property (
      OP_VALID && is_csub && RESULT_NULL_FLAG && chk_cdiff == 8'h00
      |=> RESULT_NULL_FLAG && !WB_VALID)
      else $error("chained subtract ignored the incoming borrow");

   // Borrow out of the whole chained difference
   csub_borrow_a: assert property (
      OP_VALID && is_csub
      |=> BORROW_OUT_FLAG == ({1'b0, $past(FIRST_OPERAND_REG)}
                              < ({1'b0, $past(b_sel)} + {8'h00, $past(BORROW_OUT_FLAG)})))
      else $error("chained subtract borrow flag wrong");

   // A first operand below the second always borrows
   csub_low_a: assert property (
      OP_VALID && is_csub && FIRST_OPERAND_REG < b_sel |=> BORROW_OUT_FLAG)
      else $error("chained subtract missed a borrow");

   // Chained compare keeps zero only across all bytes
   csub_null_a: assert property (
      OP_VALID && is_csub
      |=> RESULT_NULL_FLAG == (($past(chk_cdiff) == 8'h00) && $past(RESULT_NULL_FLAG)))
      else $error("chained subtract null flag wrong");

   // Left shifts move up and drop the top bit into carry
   left_out_a: assert property (
      OP_VALID && is_shift && !OP_CODE[OP_RIGHT_BIT]
      |=> WB_VALID && BORROW_OUT_FLAG == $past(FIRST_OPERAND_REG[7])
          && WB_DATA[7:1] == $past(FIRST_OPERAND_REG[6:0]))
      else $error("left shift wrong");

   // Right shifts move down and drop the low bit into carry
   right_out_a: assert property (
      OP_VALID && is_shift && OP_CODE[OP_RIGHT_BIT]
      |=> WB_VALID && BORROW_OUT_FLAG == $past(FIRST_OPERAND_REG[0])
          && WB_DATA[6:0] == $past(FIRST_OPERAND_REG[7:1]))
      else $error("right shift wrong");

   // Zero flag follows the written value
   shift_null_a: assert property (
      OP_VALID && is_shift |=> RESULT_NULL_FLAG == (WB_DATA == 8'h00))
      else $error("shift null flag wrong");

   // Sign-keeping right shift repeats the top bit
   sign_keep_a: assert property (
      OP_VALID && OP_CODE == OP_RIGHT_SHIFT_KEEP_SIGN
      |=> WB_DATA[7] == $past(FIRST_OPERAND_REG[7]))
      else $error("sign not kept");

   // Left shift through carry refills the low bit
   via_carry_a: assert property (
      OP_VALID && OP_CODE == OP_LEFT_SHIFT_VIA_CARRY
      |=> WB_DATA[0] == $past(BORROW_OUT_FLAG))
      else $error("carry not injected");

   // Right shift through carry refills the top bit
   right_carry_a: assert property (
      OP_VALID && OP_CODE == OP_RIGHT_SHIFT_VIA_CARRY
      |=> WB_DATA[7] == $past(BORROW_OUT_FLAG))
      else $error("carry not injected at the top");

   // Keep-low left shift repeats the old low bit
   keep_low_a: assert property (
      OP_VALID && OP_CODE == OP_LEFT_SHIFT_KEEP_LOW
      |=> WB_DATA[0] == $past(FIRST_OPERAND_REG[0]))
      else $error("low bit not kept");

   // Constant fills on left shifts
   left_fill_a: assert property (
      OP_VALID && (OP_CODE == OP_LEFT_SHIFT_FILL_ZERO || OP_CODE == OP_LEFT_SHIFT_FILL_ONE)
      |=> WB_DATA[0] == ($past(OP_CODE) == OP_LEFT_SHIFT_FILL_ONE))
      else $error("left fill bit wrong");

   // Constant fills on right shifts
   right_fill_a: assert property (
      OP_VALID && (OP_CODE == OP_RIGHT_SHIFT_FILL_ZERO || OP_CODE == OP_RIGHT_SHIFT_FILL_ONE)
      |=> WB_DATA[7] == ($past(OP_CODE) == OP_RIGHT_SHIFT_FILL_ONE))
      else $error("right fill bit wrong");

   // Fill one then fill zero, back to back
   fill_one_a: assert property (
      OP_VALID && OP_CODE == OP_RIGHT_SHIFT_FILL_ONE ##1 OP_VALID
      && OP_CODE == OP_LEFT_SHIFT_FILL_ZERO |=> WB_DATA[0] == 1'b0 && $past(WB_DATA[7]))
      else $error("fill bit wrong");

   // Unused codes change nothing
   ignore_code_a: assert property (
      OP_VALID && !op_known
      |=> !WB_VALID && $stable(RESULT_NULL_FLAG) && $stable(BORROW_OUT_FLAG))
      else $error("unused operation code changed state");

   // No operation, no change
   idle_hold_a: assert property (
      !OP_VALID |=> !WB_VALID && $stable(RESULT_NULL_FLAG) && $stable(BORROW_OUT_FLAG))
      else $error("state changed without an operation");

   // Main scenarios
   // Two-byte compare ending equal
   multi_compare_c: cover property (
      OP_VALID && is_sub ##1 OP_VALID && is_csub ##1 RESULT_NULL_FLAG);
   // Two-byte parity ending odd
   multi_parity_c: cover property (
      OP_VALID && is_mask ##1 OP_VALID && is_cmask ##1 BORROW_OUT_FLAG);
   // Carry handed across a pair of right shifts
   shift_chain_c: cover property (
      OP_VALID && OP_CODE == OP_RIGHT_SHIFT_FILL_ZERO ##1
      OP_VALID && OP_CODE == OP_RIGHT_SHIFT_VIA_CARRY ##1 WB_VALID && WB_DATA[7]);
   // Compare that borrows
   compare_less_c: cover property (OP_VALID && is_sub ##1 BORROW_OUT_FLAG);
   // Unused code presented
   ignored_code_c: cover property (OP_VALID && !op_known);

endmodule

// ==== tb/fta_core_model.sv ====
/*
 Core-side partner: decoder issuing one op per cycle, four-entry register file.
 Assumes issue is called once per cycle and load only when no write-back is due.
*/
`timescale 1ns/10ps
module fta_core_model
   import fta_pkg::*;
(
   // Clock
   input wire logic clk,
   // Operation to the datapath
   output logic op_valid,
   output logic [3:0] op_code,
   output logic use_second_reg,
   output logic [7:0] first_operand_reg,
   output logic [7:0] second_operand_reg,
   output logic [7:0] immediate_byte,
   // Write-back from the datapath
   input wire logic wb_valid,
   input wire logic [7:0] wb_data
);
   logic [7:0] rf [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic [1:0] x_idx = 2'h0;
   logic [1:0] wb_idx_q = 2'h0;

   // Idle at time zero
   initial begin
      op_valid = 1'b0;
      op_code = 4'h0;
      use_second_reg = 1'b0;
      first_operand_reg = 8'h00;
      second_operand_reg = 8'h00;
      immediate_byte = 8'h00;
   end

   // Store write-back, track the target of each taken op
   always @(posedge clk) begin
      if (wb_valid) rf[wb_idx_q] <= wb_data;
      if (op_valid) wb_idx_q <= x_idx;
   end

   // Read with forwarding of a write-back not yet stored
   function automatic logic [7:0] rd(input logic [1:0] i);
      return (wb_valid && wb_idx_q == i) ? wb_data : rf[i];
   endfunction

   // Unused operands carry noise, never the last value
   task automatic issue(input logic v, input logic [3:0] op, input logic sel,
         input logic [1:0] x, input logic [1:0] y, input logic [7:0] imm);
      @(negedge clk);
      op_valid = v;
      op_code = v ? op : 4'($urandom);
      use_second_reg = sel;
      x_idx = x;
      first_operand_reg = v ? rd(x) : 8'($urandom);
      second_operand_reg = (v && sel) ? rd(y) : 8'($urandom);
      immediate_byte = (v && !sel) ? imm : 8'($urandom);
   endtask

   task automatic load(input logic [1:0] i, input logic [7:0] val);
      rf[i] <= val;
   endtask
endmodule

// ==== tb/test_flag_test_compare_shift_alu.sv ====
/*
 Self-checking bench: reference flags and write-back queued per op, checked
 by a monitor. Assumes outputs settle one cycle after a taken op.
*/
`timescale 1ns/10ps
module test_flag_test_compare_shift_alu;
   import fta_pkg::*;
   typedef struct packed {logic z; logic c; logic v; logic [7:0] d;} fta_exp_t;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic OP_VALID, USE_SECOND_REG, RESULT_NULL_FLAG, BORROW_OUT_FLAG, WB_VALID;
   logic [3:0] OP_CODE;
   logic [7:0] FIRST_OPERAND_REG, SECOND_OPERAND_REG, IMMEDIATE_BYTE, WB_DATA;
   logic taken = 1'b0;
   logic ez = 1'b0;
   logic ec = 1'b0;
   logic [7:0] ed = 8'h00;
   logic [7:0] mir [4];
   fta_exp_t exp_q [$];
   fta_exp_t e;
   int n_errors = 0;
   int comparisons = 0;

   always #10 CLK = ~CLK;

   fta_core_model core (.clk(CLK), .op_valid(OP_VALID), .op_code(OP_CODE),
      .use_second_reg(USE_SECOND_REG), .first_operand_reg(FIRST_OPERAND_REG),
      .second_operand_reg(SECOND_OPERAND_REG), .immediate_byte(IMMEDIATE_BYTE),
      .wb_valid(WB_VALID), .wb_data(WB_DATA));

   fta_alu dut (.CLK(CLK), .RST_B(RST_B), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
      .USE_SECOND_REG(USE_SECOND_REG), .FIRST_OPERAND_REG(FIRST_OPERAND_REG),
      .SECOND_OPERAND_REG(SECOND_OPERAND_REG), .IMMEDIATE_BYTE(IMMEDIATE_BYTE),
      .RESULT_NULL_FLAG(RESULT_NULL_FLAG), .BORROW_OUT_FLAG(BORROW_OUT_FLAG),
      .WB_VALID(WB_VALID), .WB_DATA(WB_DATA));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expv);
      comparisons++;
      if (seen !== expv) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Reference model, then hand the op to the decoder model
   task automatic run(input logic [3:0] op, input logic sel, input logic [1:0] x,
         input logic [1:0] y, input logic [7:0] imm);
      logic [7:0] a, b, t;
      logic [8:0] s;
      logic f, sh;
      a = mir[x];
      b = sel ? mir[y] : imm;
      t = a & b;
      sh = 1'b0;
      if (op[3:1] == 3'h0) begin
         ez = (t == 8'h00) && (!op[0] || ez);
         ec = ^t ^ (op[0] & ec);
      end else if (op[3:1] == 3'h1) begin
         s = {1'b0, a} - {1'b0, b} - {8'h00, op[0] & ec};
         ez = (s[7:0] == 8'h00) && (!op[0] || ez);
         ec = s[8];
      end else if (op[3]) begin
         f = op[1] ? (op[0] ? ec : (op[2] ? a[7] : a[0])) : op[0];
         sh = 1'b1;
         ec = op[2] ? a[0] : a[7];
         ed = op[2] ? {f, a[7:1]} : {a[6:0], f};
         ez = (ed == 8'h00);
         mir[x] = ed;
      end
      exp_q.push_back({ez, ec, sh, ed});
      core.issue(1'b1, op, sel, x, y, imm);
   endtask

   task automatic idle(input int n);
      repeat (n) core.issue(1'b0, 4'h0, 1'b0, 2'h0, 2'h0, 8'h00);
   endtask

   task automatic preload(input logic [7:0] v0, v1, v2, v3);
      idle(2);
      mir = '{v0, v1, v2, v3};
      for (int i = 0; i < 4; i++) core.load(2'(i), mir[i]);
   endtask

   task automatic reset_check;
      idle(2);
      RST_B = 1'b0;
      repeat (4) @(negedge CLK);
      check("reset", {RESULT_NULL_FLAG, BORROW_OUT_FLAG, WB_VALID, WB_DATA[4:0]}, 8'h00);
      check("reset wb_data", WB_DATA, WB_DATA_RST);
      RST_B = 1'b1;
      {ez, ec, ed} = 10'h000;
   endtask

   // Monitor: one noted result per taken op, quiet write-back otherwise
   always @(posedge CLK) taken <= OP_VALID && RST_B;
   always @(negedge CLK) begin
      if (taken) begin
         e = exp_q.pop_front();
         check("null", {7'h00, RESULT_NULL_FLAG}, {7'h00, e.z});
         check("borrow", {7'h00, BORROW_OUT_FLAG}, {7'h00, e.c});
         check("wb_valid", {7'h00, WB_VALID}, {7'h00, e.v});
         check("wb_data", WB_DATA, e.d);
      end else if (RST_B) begin
         check("wb_valid idle", {7'h00, WB_VALID}, 8'h00);
      end
   end

   // Watchdog
   initial begin
      #(5000 * 20);
      n_errors++;
      final_report();
   end

   initial begin
      void'($urandom(1519));
      repeat (4) @(negedge CLK);
      RST_B = 1'b1;
      preload(8'h03, 8'h8e, 8'hca, 8'h52);
      run(4'hc, 1'b0, 2'h0, 2'h0, 8'h00);
      run(4'h2, 1'b0, 2'h1, 2'h0, 8'h98);
      run(4'h0, 1'b0, 2'h2, 2'h0, 8'hff);
      run(4'h1, 1'b0, 2'h3, 2'h0, 8'hff);
      run(4'h0, 1'b0, 2'h2, 2'h0, 8'h04);
      run(4'h1, 1'b1, 2'h3, 2'h1, 8'h20);
      preload(8'h7b, 8'ha2, 8'h14, 8'h81);
      run(4'h2, 1'b1, 2'h0, 2'h0, 8'h00);
      run(4'h3, 1'b0, 2'h1, 2'h0, 8'ha2);
      run(4'h3, 1'b0, 2'h2, 2'h0, 8'h14);
      run(4'he, 1'b0, 2'h3, 2'h0, 8'h00);
      run(4'hb, 1'b0, 2'h3, 2'h0, 8'h00);
      run(4'hf, 1'b0, 2'h3, 2'h0, 8'h00);
      run(4'hd, 1'b0, 2'h3, 2'h0, 8'h00);
      run(4'h8, 1'b0, 2'h3, 2'h0, 8'h00);
      run(4'h9, 1'b0, 2'h3, 2'h0, 8'h00);
      run(4'ha, 1'b0, 2'h3, 2'h0, 8'h00);
      reset_check();
      for (int i = 0; i < 400; i++) begin
         if ($urandom % 5 == 0) idle(1);
         else run(4'($urandom), 1'($urandom), 2'($urandom), 2'($urandom), 8'($urandom));
      end
      idle(3);
      for (int i = 0; i < 4; i++) check("register", core.rf[i], mir[i]);
      final_report();
   end
endmodule
